/* dwc_pkg.sv */
/*
  Shared constants for the disk write command engine: register offsets,
  command opcodes, bit positions, reset values and the sequencer states.
  Assumes a byte-addressed register port with 32-bit data.
*/
package dwc_pkg;
  // Register offsets
  localparam logic [7:0] OFF_SECCNT = 8'h00;
  localparam logic [7:0] OFF_ADDR   = 8'h04;
  localparam logic [7:0] OFF_CMD    = 8'h08;
  localparam logic [7:0] OFF_ERR    = 8'h0c;
  localparam logic [7:0] OFF_CTRL   = 8'h10;
  localparam logic [7:0] OFF_MULT   = 8'h14;
  localparam logic [7:0] OFF_DATA   = 8'h18;
  localparam logic [7:0] OFF_ISTAT  = 8'h1c;
  localparam logic [7:0] OFF_IMASK  = 8'h20;
  // Command opcodes
  localparam logic [7:0] OP_WR_SEC   = 8'h30;
  localparam logic [7:0] OP_WR_SEC_X = 8'h34;
  localparam logic [7:0] OP_WR_MUL   = 8'hc5;
  localparam logic [7:0] OP_WR_MUL_X = 8'h39;
  localparam logic [7:0] OP_WR_RAW   = 8'h32;
  // Status bits (read at OFF_CMD)
  localparam int ST_BSY = 0;
  localparam int ST_DRQ = 1;
  localparam int ST_ERR = 2;
  // Error register bits
  localparam int ER_ABRT = 2;
  localparam int ER_IDNF = 4;
  localparam int ER_MED  = 6;
  // Control register bits
  localparam int CT_LBA    = 0;
  localparam int CT_RETRY  = 1;
  localparam int CT_MULEN  = 2;
  localparam int CT_ECCNAT = 3;
  // Interrupt status and mask bits
  localparam int IQ_BLK  = 0;
  localparam int IQ_DONE = 1;
  localparam int IQ_ERR  = 2;
  localparam int IQ_W    = 3;
  // Address fields in CHS form
  localparam int SEC_LSB = 0;
  localparam int CYL_LSB = 8;
  localparam int HD_LSB  = 24;
  // Short check-byte length
  localparam int ECC_SHORT = 4;
  // Reset values
  localparam logic [3:0]  CTRL_RST = 4'h6;
  localparam logic [7:0]  MULT_RST = 8'h00;
  localparam logic [27:0] ADDR_RST = 28'h0000001;
  localparam logic [7:0]  CNT_RST  = 8'h01;

  typedef enum {
    S_IDLE, S_BLK, S_FILL, S_SEEK, S_SRCH, S_WRT, S_ECC, S_WAIT, S_NEXT
  } dwc_state_t;
endpackage

/* dwc_id_search.sv */
/*
  Sector identifier search: counts index pulses until the channel reports
  a clean identifier or the revolution limit runs out.
  Assumes index and identifier strobes come from same-clock channel logic.
*/
`timescale 1ns/10ps
module dwc_id_search
  import dwc_pkg::*;
#(
  parameter int RETRIES = 8
) (
  input  logic ref_clk,
  input  logic rst,
  input  logic start,
  input  logic retry_en,
  input  logic index_pulse,
  input  logic id_ok,
  output logic found,
  output logic not_found
);
  localparam int CW = $clog2(2 * RETRIES + 1);

  logic          active_q;
  logic [CW-1:0] idx_q;
  logic [CW-1:0] limit;

  // Two revolutions per attempt
  assign limit = retry_en ? CW'(2 * RETRIES) : CW'(2);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      active_q  <= 1'b0;
      idx_q     <= '0;
      found     <= 1'b0;
      not_found <= 1'b0;
    end else begin
      found     <= 1'b0;
      not_found <= 1'b0;
      if (start) begin
        active_q <= 1'b1;
        idx_q    <= '0;
      end else if (active_q) begin
        if (id_ok) begin
          found    <= 1'b1;
          active_q <= 1'b0;
        end else if (index_pulse) begin
          if (idx_q + CW'(1) == limit) begin
            not_found <= 1'b1;
            active_q  <= 1'b0;
          end else begin
            idx_q <= idx_q + CW'(1);
          end
        end
      end
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_idnf_two_index: assert property (
    not_found && !$past(retry_en) |-> $past(idx_q) == CW'(1)
      && $past(index_pulse))
    else $error("identifier miss not after two index pulses");
  a_found_clean: assert property (
    found |-> $past(id_ok) && $past(active_q))
    else $error("identifier found without a clean read");
endmodule

/* dwc_irq.sv */
/*
  Sticky interrupt status with mask and one level interrupt output.
  Assumes events are one-cycle pulses on the same clock.
*/
`timescale 1ns/10ps
module dwc_irq
  import dwc_pkg::*;
(
  input  logic            ref_clk,
  input  logic            rst,
  input  logic [IQ_W-1:0] events,
  input  logic            clr_wr,
  input  logic            mask_wr,
  input  logic [IQ_W-1:0] wdata,
  output logic [IQ_W-1:0] stat_q,
  output logic [IQ_W-1:0] mask_q,
  output logic            irq_q
);
  logic [IQ_W-1:0] clr;

  assign clr = clr_wr ? wdata : '0;

  // A set in the clearing cycle wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stat_q <= '0;
      mask_q <= '0;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~clr) | events;
      if (mask_wr) begin
        mask_q <= wdata;
      end
      irq_q <= |(stat_q & mask_q);
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_err_sticky: assert property (
    events[IQ_ERR] |=> stat_q[IQ_ERR])
    else $error("error event not latched");
endmodule

/* dwc_engine.sv */
/*
  Drive-side engine for the raw, block and plain sector write commands:
  command check, blocking, data buffer, seek, identifier search, media
  write and result registers. Assumes a same-clock media channel that
  accepts one word per cycle and a single-cycle register master.
*/
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module dwc_engine
  import dwc_pkg::*;
#(
  parameter int WORDS      = 128,
  parameter int MAX_MULT   = 16,
  parameter int ECC_NATIVE = 4,
  parameter int RETRIES    = 8,
  parameter int SPT        = 63,
  parameter int HEADS      = 16
) (
  input  logic        ref_clk,
  input  logic        rst,
  input  logic [7:0]  reg_addr,
  input  logic [31:0] reg_wdata,
  input  logic        reg_wr,
  input  logic        reg_rd,
  output logic [31:0] reg_rdata,
  output logic        irq,
  output logic        med_seek,
  output logic [27:0] med_target,
  input  logic        med_on_track,
  input  logic        med_index,
  input  logic        med_id_ok,
  output logic        med_id_start,
  output logic        med_wvalid,
  output logic        med_wecc,
  output logic [31:0] med_wdata,
  output logic        med_host_ecc,
  input  logic        med_wr_done,
  input  logic        med_wr_err
);
  localparam int ECC_MAX = (ECC_NATIVE > ECC_SHORT) ? ECC_NATIVE : ECC_SHORT;
  localparam int DEPTH   = MAX_MULT * WORDS + ECC_MAX;
  localparam int AW      = $clog2(DEPTH + 1);

  dwc_state_t      state_q;
  logic [31:0]     mem [DEPTH];
  logic [7:0]      seccnt_q;
  logic [27:0]     addr_q;
  logic [7:0]      err_q;
  logic [3:0]      ctrl_q;
  logic [7:0]      mult_q;
  logic            mult_set_q;
  logic            bsy_q;
  logic            drq_q;
  logic            errb_q;
  logic            raw_q;
  logic            multi_q;
  logic            blk_err_q;
  logic            skq;
  logic [8:0]      left_q;
  logic [8:0]      blk_q;
  logic [8:0]      sec_q;
  logic [AW-1:0]   fill_q;
  logic [AW-1:0]   need_q;
  logic [AW-1:0]   rd_ptr_q;
  logic [AW-1:0]   wcnt_q;
  logic            ev_blk_q;
  logic            ev_done_q;
  logic            ev_err_q;
  logic [IQ_W-1:0] istat;
  logic [IQ_W-1:0] imask;
  logic            id_found;
  logic            id_nf;
  logic            wr_cmd;
  logic            wr_data;
  logic            is_mul;
  logic            is_raw;
  logic            is_sec;
  logic            bad_cmd;
  logic [8:0]      total;
  logic [8:0]      bs;
  logic [8:0]      nb;
  logic [AW-1:0]   ecc_len;

  function automatic logic [27:0] next_addr(input logic [27:0] a,
                                            input logic        lba);
    logic [27:0] n;
    n = a;
    if (lba) begin
      n = a + 28'h0000001;
    end else if (a[SEC_LSB+:8] < 8'(SPT)) begin
      n[SEC_LSB+:8] = a[SEC_LSB+:8] + 8'h01;
    end else begin
      n[SEC_LSB+:8] = 8'h01;
      if (a[HD_LSB+:4] < 4'(HEADS - 1)) begin
        n[HD_LSB+:4] = a[HD_LSB+:4] + 4'h1;
      end else begin
        n[HD_LSB+:4]  = 4'h0;
        n[CYL_LSB+:16] = a[CYL_LSB+:16] + 16'h0001;
      end
    end
    return n;
  endfunction

  assign wr_cmd  = reg_wr && reg_addr == OFF_CMD;
  assign wr_data = reg_wr && reg_addr == OFF_DATA;
  assign is_mul  = reg_wdata[7:0] == OP_WR_MUL
                || reg_wdata[7:0] == OP_WR_MUL_X;
  assign is_raw  = reg_wdata[7:0] == OP_WR_RAW;
  assign is_sec  = reg_wdata[7:0] == OP_WR_SEC
                || reg_wdata[7:0] == OP_WR_SEC_X;
  assign bad_cmd = !(is_mul || is_raw || is_sec)
                || (is_mul && !(mult_set_q && ctrl_q[CT_MULEN]))
                || (is_raw && seccnt_q != 8'h01);
  assign total   = (seccnt_q == 8'h00) ? 9'h100 : {1'b0, seccnt_q};
  assign ecc_len = ctrl_q[CT_ECCNAT] ? AW'(ECC_NATIVE) : AW'(ECC_SHORT);

  // Block size from the multiple setting, last block takes the rest
  always_comb begin
    bs = multi_q ? {1'b0, mult_q} : 9'h001;
    nb = (left_q < bs) ? left_q : bs;
  end

  // Software configuration
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q     <= CTRL_RST;
      mult_q     <= MULT_RST;
      mult_set_q <= 1'b0;
    end else if (reg_wr && state_q == S_IDLE) begin
      if (reg_addr == OFF_CTRL) begin
        ctrl_q <= reg_wdata[3:0];
      end
      if (reg_addr == OFF_MULT) begin
        mult_q     <= reg_wdata[7:0];
        mult_set_q <= reg_wdata[7:0] != 8'h00
                   && reg_wdata[7:0] <= 8'(MAX_MULT);
      end
    end
  end

  // Sector buffer fill
  always_ff @(posedge ref_clk) begin
    if (state_q == S_FILL && wr_data) begin
      mem[fill_q] <= reg_wdata;
    end
  end

  // Command sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q      <= S_IDLE;
      seccnt_q     <= CNT_RST;
      addr_q       <= ADDR_RST;
      err_q        <= 8'h00;
      bsy_q        <= 1'b0;
      drq_q        <= 1'b0;
      errb_q       <= 1'b0;
      raw_q        <= 1'b0;
      multi_q      <= 1'b0;
      blk_err_q    <= 1'b0;
      skq          <= 1'b0;
      left_q       <= 9'h000;
      blk_q        <= 9'h000;
      sec_q        <= 9'h000;
      fill_q       <= '0;
      need_q       <= '0;
      rd_ptr_q     <= '0;
      wcnt_q       <= '0;
      ev_blk_q     <= 1'b0;
      ev_done_q    <= 1'b0;
      ev_err_q     <= 1'b0;
      med_seek     <= 1'b0;
      med_id_start <= 1'b0;
      med_wvalid   <= 1'b0;
      med_wecc     <= 1'b0;
      med_wdata    <= 32'h00000000;
    end else begin
      ev_blk_q     <= 1'b0;
      ev_done_q    <= 1'b0;
      ev_err_q     <= 1'b0;
      med_seek     <= 1'b0;
      med_id_start <= 1'b0;
      med_wvalid   <= 1'b0;
      med_wecc     <= 1'b0;
      unique case (state_q)
        S_IDLE: begin
          if (reg_wr && reg_addr == OFF_SECCNT) begin
            seccnt_q <= reg_wdata[7:0];
          end
          if (reg_wr && reg_addr == OFF_ADDR) begin
            addr_q <= reg_wdata[27:0];
          end
          if (wr_cmd) begin
            if (bad_cmd) begin
              err_q    <= 8'h01 << ER_ABRT;
              errb_q   <= 1'b1;
              ev_err_q <= 1'b1;
            end else begin
              err_q   <= 8'h00;
              errb_q  <= 1'b0;
              bsy_q   <= 1'b1;
              raw_q   <= is_raw;
              multi_q <= is_mul;
              left_q  <= total;
              state_q <= S_BLK;
            end
          end
        end
        S_BLK: begin
          blk_q     <= nb;
          sec_q     <= 9'h000;
          fill_q    <= '0;
          rd_ptr_q  <= '0;
          need_q    <= AW'(nb * WORDS) + (raw_q ? ecc_len : '0);
          blk_err_q <= 1'b0;
          bsy_q     <= 1'b0;
          drq_q     <= 1'b1;
          ev_blk_q  <= 1'b1;
          state_q   <= S_FILL;
        end
        S_FILL: begin
          if (wr_data) begin
            fill_q <= fill_q + AW'(1);
            if (fill_q == need_q - AW'(1)) begin
              drq_q   <= 1'b0;
              bsy_q   <= 1'b1;
              skq     <= 1'b0;
              state_q <= S_SEEK;
            end
          end
        end
        S_SEEK: begin
          if (med_on_track) begin
            med_id_start <= 1'b1;
            state_q      <= S_SRCH;
          end else if (!skq) begin
            med_seek <= 1'b1;
            skq      <= 1'b1;
          end
        end
        S_SRCH: begin
          if (id_found) begin
            wcnt_q  <= '0;
            state_q <= S_WRT;
          end else if (id_nf) begin
            err_q[ER_IDNF] <= 1'b1;
            if (multi_q) begin
              blk_err_q <= 1'b1;
              rd_ptr_q  <= rd_ptr_q + AW'(WORDS);
              state_q   <= S_NEXT;
            end else begin
              bsy_q     <= 1'b0;
              errb_q    <= 1'b1;
              ev_done_q <= 1'b1;
              ev_err_q  <= 1'b1;
              state_q   <= S_IDLE;
            end
          end
        end
        S_WRT: begin
          med_wvalid <= 1'b1;
          med_wdata  <= mem[rd_ptr_q];
          rd_ptr_q   <= rd_ptr_q + AW'(1);
          wcnt_q     <= wcnt_q + AW'(1);
          if (wcnt_q == AW'(WORDS - 1)) begin
            wcnt_q  <= '0;
            state_q <= raw_q ? S_ECC : S_WAIT;
          end
        end
        S_ECC: begin
          med_wecc  <= 1'b1;
          med_wdata <= {24'h000000, mem[rd_ptr_q][7:0]};
          rd_ptr_q  <= rd_ptr_q + AW'(1);
          wcnt_q    <= wcnt_q + AW'(1);
          if (wcnt_q == ecc_len - AW'(1)) begin
            state_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (med_wr_done) begin
            if (!med_wr_err) begin
              state_q <= S_NEXT;
            end else if (multi_q) begin
              err_q[ER_MED] <= 1'b1;
              blk_err_q     <= 1'b1;
              state_q       <= S_NEXT;
            end else begin
              err_q[ER_MED] <= 1'b1;
              bsy_q         <= 1'b0;
              errb_q        <= 1'b1;
              ev_done_q     <= 1'b1;
              ev_err_q      <= 1'b1;
              state_q       <= S_IDLE;
            end
          end
        end
        S_NEXT: begin
          if (left_q == 9'h001
              || (sec_q + 9'h001 == blk_q && blk_err_q)) begin
            bsy_q     <= 1'b0;
            errb_q    <= blk_err_q;
            ev_done_q <= 1'b1;
            ev_err_q  <= blk_err_q;
            state_q   <= S_IDLE;
          end else begin
            addr_q <= next_addr(addr_q, ctrl_q[CT_LBA]);
            left_q <= left_q - 9'h001;
            if (sec_q + 9'h001 == blk_q) begin
              state_q <= S_BLK;
            end else begin
              sec_q   <= sec_q + 9'h001;
              skq     <= 1'b0;
              state_q <= S_SEEK;
            end
          end
        end
      endcase
    end
  end

  // Registered side outputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      med_target   <= ADDR_RST;
      med_host_ecc <= 1'b0;
    end else begin
      med_target   <= addr_q;
      med_host_ecc <= raw_q && bsy_q;
    end
  end

  // Register read, data one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        unique case (reg_addr)
          OFF_SECCNT: reg_rdata <= {24'h000000, seccnt_q};
          OFF_ADDR:   reg_rdata <= {4'h0, addr_q};
          OFF_CMD:    reg_rdata <= {29'h0, errb_q, drq_q, bsy_q};
          OFF_ERR:    reg_rdata <= {24'h000000, err_q};
          OFF_CTRL:   reg_rdata <= {28'h0000000, ctrl_q};
          OFF_MULT:   reg_rdata <= {23'h0, mult_set_q, mult_q};
          OFF_ISTAT:  reg_rdata <= {29'h0, istat};
          OFF_IMASK:  reg_rdata <= {29'h0, imask};
          default:    reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  dwc_id_search #(
    .RETRIES (RETRIES)
  ) u_search (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .start       (med_id_start),
    .retry_en    (ctrl_q[CT_RETRY]),
    .index_pulse (med_index),
    .id_ok       (med_id_ok),
    .found       (id_found),
    .not_found   (id_nf)
  );

  dwc_irq u_irq (
    .ref_clk (ref_clk),
    .rst     (rst),
    .events  ({ev_err_q, ev_done_q, ev_blk_q}),
    .clr_wr  (reg_wr && reg_addr == OFF_ISTAT),
    .mask_wr (reg_wr && reg_addr == OFF_IMASK),
    .wdata   (reg_wdata[IQ_W-1:0]),
    .stat_q  (istat),
    .mask_q  (imask),
    .irq_q   (irq)
  );

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_raw_single: assert property (
    wr_cmd && state_q == S_IDLE && is_raw && seccnt_q != 8'h01
      |=> state_q == S_IDLE && err_q[ER_ABRT] && ev_err_q)
    else $error("raw write of more than one sector accepted");
  a_ecc_bytes: assert property (
    $rose(med_wecc) |-> (med_wecc && med_host_ecc
      && med_wdata[31:8] == 24'h000000)[*4])
    else $error("check bytes not sent as four byte beats");
  a_blk_irq: assert property (
    $rose(drq_q) |-> ev_blk_q && state_q == S_FILL)
    else $error("block start without interrupt event");
  a_drq_block: assert property (
    state_q == S_FILL |-> drq_q && !bsy_q)
    else $error("data request dropped inside a block");
  a_blk_size: assert property (
    state_q == S_FILL |-> blk_q != 9'h000 && blk_q <= bs)
    else $error("block size outside the multiple setting");
  a_mult_abort: assert property (
    wr_cmd && state_q == S_IDLE && is_mul && !mult_set_q
      |=> state_q == S_IDLE && err_q[ER_ABRT] && !bsy_q)
    else $error("block write without multiple not aborted");
  a_count_zero: assert property (
    wr_cmd && state_q == S_IDLE && is_sec && seccnt_q == 8'h00
      |=> left_q == 9'h100)
    else $error("zero count not taken as 256 sectors");
  a_seek_off: assert property (
    med_seek |-> $past(!med_on_track) && state_q == S_SEEK)
    else $error("seek issued while on track");
  a_stop_fail: assert property (
    state_q == S_SRCH && id_nf && !multi_q
      |=> state_q == S_IDLE && err_q[ER_IDNF] && $stable(addr_q))
    else $error("write not stopped at failing sector");
  a_blk_late: assert property (
    multi_q && state_q == S_WAIT && med_wr_done && med_wr_err
      |=> state_q == S_NEXT && bsy_q)
    else $error("block error posted before block end");
endmodule

/* dwc_media_model.sv */
/*
  Media channel model: index, seek settle, identifier search, write done.
  Assumes the engine's same-clock media port and bench-set fault inputs.
*/
`timescale 1ns/10ps
module dwc_media_model (
  input  logic        ref_clk,
  input  logic        rst,
  input  logic        med_seek,
  input  logic [27:0] med_target,
  input  logic        med_id_start,
  input  logic        med_wvalid,
  input  logic        med_wecc,
  input  logic        med_host_ecc,
  input  logic [31:0] med_wdata,
  input  logic        miss,
  input  logic [9:0]  err_at,
  output logic        med_on_track,
  output logic        med_index,
  output logic        med_id_ok,
  output logic        med_wr_done,
  output logic        med_wr_err,
  output logic [9:0]  n_done,
  output logic [15:0] n_words,
  output logic [15:0] n_ecc,
  output logic [31:0] wsum
);
  logic [27:0] trk_q;
  logic [3:0]  idx_q, id_q, idle_q;
  logic [1:0]  sk_q;
  logic        pend_q;

  // Free-running rotation index
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      idx_q <= 4'h0;
      med_index <= 1'b0;
    end else begin
      idx_q <= idx_q + 4'h1;
      med_index <= (idx_q == 4'hf);
    end
  end

  // Off track when the target track (bits 27:4) moves, on track 3 cycles after seek
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      trk_q <= 28'h0;
      sk_q <= 2'h0;
      med_on_track <= 1'b0;
    end else begin
      trk_q <= med_target;
      sk_q <= med_seek ? 2'h3 : sk_q - {1'b0, sk_q != 2'h0};
      if (med_target[27:4] != trk_q[27:4]) begin
        med_on_track <= 1'b0;
      end else if (sk_q == 2'h1) begin
        med_on_track <= 1'b1;
      end
    end
  end

  // Identifier found 5 cycles after search start unless missing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      id_q <= 4'h0;
      med_id_ok <= 1'b0;
    end else begin
      id_q <= med_id_start ? 4'h5 : id_q - {3'h0, id_q != 4'h0};
      med_id_ok <= (id_q == 4'h1) && !miss;
    end
  end

  // Sector done 3 idle cycles after the last beat
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_q <= 1'b0;
      idle_q <= 4'h0;
      med_wr_done <= 1'b0;
      med_wr_err <= 1'b0;
      n_done <= 10'h0;
      n_words <= 16'h0;
      n_ecc <= 16'h0;
      wsum <= 32'h0;
    end else begin
      wsum <= wsum + ((med_wvalid || med_wecc) ? med_wdata : 32'h0);
      n_words <= n_words + {15'h0, med_wvalid};
      n_ecc <= n_ecc + {15'h0, med_wecc && med_host_ecc};
      med_wr_done <= pend_q && idle_q == 4'h3;
      med_wr_err <= pend_q && idle_q == 4'h3 && n_done + 10'h1 == err_at;
      if (med_wvalid || med_wecc) begin
        pend_q <= 1'b1;
        idle_q <= 4'h0;
      end else if (pend_q && idle_q == 4'h3) begin
        pend_q <= 1'b0;
        n_done <= n_done + 10'h1;
      end else if (pend_q) begin
        idle_q <= idle_q + 4'h1;
      end
    end
  end
endmodule

/* disk_write_command_engine_tb.sv */
/*
  Bench for the write engine: register tasks and command runs with checks.
  Assumes the media model beside the engine and one 10 MHz clock.
*/
`timescale 1ns/10ps
module disk_write_command_engine_tb;
  import dwc_pkg::*;
  localparam int ECC_N = 6;
  logic        ref_clk, rst, reg_wr, reg_rd, irq, miss;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, med_wdata, s, wsum, s0;
  logic        seek, on_trk, idx, id_ok, id_st, wv, we, hecc, done, werr;
  logic [27:0] tgt;
  logic [9:0]  err_at, n_done;
  logic [15:0] n_words, n_ecc, w0, e0;
  int          n_fail = 0, num_checks = 0, mult = 0, b;
  logic [7:0]  ops [3] = '{OP_WR_MUL, OP_WR_MUL_X, OP_WR_RAW};
  logic [3:0]  ctls [3] = '{4'h7, 4'h3, 4'h7};

  dwc_engine #(.WORDS(4), .RETRIES(2), .ECC_NATIVE(ECC_N)) dut (
    .ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .med_seek(seek),
    .med_target(tgt), .med_on_track(on_trk), .med_index(idx),
    .med_id_ok(id_ok), .med_id_start(id_st), .med_wvalid(wv),
    .med_wecc(we), .med_wdata(med_wdata), .med_host_ecc(hecc),
    .med_wr_done(done), .med_wr_err(werr));
  dwc_media_model media (.ref_clk(ref_clk), .rst(rst), .med_seek(seek),
    .med_target(tgt), .med_id_start(id_st), .med_wvalid(wv), .med_wecc(we),
    .med_host_ecc(hecc), .miss(miss), .err_at(err_at),
    .med_on_track(on_trk), .med_index(idx), .med_id_ok(id_ok),
    .med_wr_done(done), .med_wr_err(werr), .n_done(n_done),
    .n_words(n_words), .n_ecc(n_ecc), .med_wdata(med_wdata),
    .wsum(wsum));

  always #50 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Issue a command, feed each data request, poll until idle
  task automatic run(input logic [7:0] op, input logic [7:0] cnt,
                     input logic [27:0] adr, input logic [3:0] ctl);
    int rem, n, lim;
    logic [31:0] t;
    b = 0;
    lim = 0;
    rem = (cnt == 8'h00) ? 256 : int'(cnt);
    w0 = n_words;
    e0 = n_ecc;
    s0 = wsum;
    wr(OFF_CTRL, {28'h0, ctl});
    wr(OFF_SECCNT, {24'h0, cnt});
    wr(OFF_ADDR, {4'h0, adr});
    wr(OFF_IMASK, 32'h7);
    wr(OFF_ISTAT, 32'h7);
    wr(OFF_CMD, {24'h0, op});
    do begin
      rd(OFF_CMD, t);
      lim++;
      if (t[ST_DRQ]) begin
        rd(OFF_ISTAT, s);
        b += int'(s[IQ_BLK]);
        wr(OFF_ISTAT, 32'h1);
        n = (op == OP_WR_MUL || op == OP_WR_MUL_X) && rem > mult ? mult : 1;
        n = (op == OP_WR_MUL || op == OP_WR_MUL_X) && rem <= mult ? rem : n;
        rem -= n;
        for (int i = 0; i < n * 4; i++) wr(OFF_DATA, 32'hd0000000 + 32'(i));
        for (int i = 0; i < (ctl[3] ? ECC_N : ECC_SHORT) && op == OP_WR_RAW;
             i++) wr(OFF_DATA, 32'(i));
      end
    end while ((t[ST_BSY] || t[ST_DRQ]) && lim < 20000);
    chk({31'h0, lim >= 20000}, 32'h0);
  endtask

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    miss = 1'b0;
    err_at = 10'h0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rd(OFF_SECCNT, s);
    chk(s, {24'h0, CNT_RST});
    rd(OFF_ADDR, s);
    chk(s, {4'h0, ADDR_RST});
    rd(OFF_CTRL, s);
    chk(s, {28'h0, CTRL_RST});
    rd(OFF_MULT, s);
    chk(s, 32'h0);
    rd(8'h24, s);
    chk(s, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      if (i == 1) wr(OFF_MULT, 32'h2);
      run(ops[i], 8'h02, 28'h10, ctls[i]);
      rd(OFF_ERR, s);
      chk({31'h0, s[ER_ABRT]}, 32'h1);
      rd(OFF_CMD, s);
      chk({29'h0, s[2:0]}, 32'h4);
      chk({31'h0, irq}, 32'h1);
      wr(OFF_ISTAT, 32'h7);
      repeat (3) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h0);
    end
    $display("test abort done");
    mult = 2;
    run(OP_WR_SEC, 8'h02, 28'h10, 4'h7);
    rd(OFF_ADDR, s);
    chk(s, 32'h11);
    chk({16'h0, n_words - w0}, 32'd8);
    run(OP_WR_SEC_X, 8'h01, 28'h1000503, 4'h6);
    rd(OFF_ADDR, s);
    chk(s, 32'h1000503);
    run(OP_WR_SEC, 8'h00, 28'h100, 4'h7);
    chk({16'h0, n_words - w0}, 32'd1024);
    rd(OFF_ADDR, s);
    chk(s, 32'h1ff);
    $display("test sector write done");
    run(OP_WR_MUL_X, 8'h05, 28'h20, 4'h7);
    chk(32'(b), 32'd3);
    chk({16'h0, n_words - w0}, 32'd20);
    rd(OFF_ADDR, s);
    chk(s, 32'h24);
    run(OP_WR_RAW, 8'h01, 28'h40, 4'h7);
    chk({16'h0, n_ecc - e0}, 32'd4);
    chk({16'h0, n_words - w0}, 32'd4);
    chk(wsum - s0, 32'h4000000c);
    run(OP_WR_RAW, 8'h01, 28'h41, 4'hf);
    chk({16'h0, n_ecc - e0}, 32'(ECC_N));
    chk(wsum - s0, 32'h40000015);
    $display("test block and raw done");
    miss = 1'b1;
    for (int i = 0; i < 2; i++) begin
      run(OP_WR_SEC, 8'h01, 28'h50, i ? 4'h7 : 4'h5);
      rd(OFF_ERR, s);
      chk({31'h0, s[ER_IDNF]}, 32'h1);
    end
    miss = 1'b0;
    err_at = n_done + 10'h2;
    run(OP_WR_SEC, 8'h03, 28'h60, 4'h7);
    rd(OFF_ADDR, s);
    chk(s, 32'h61);
    chk({16'h0, n_words - w0}, 32'd8);
    rd(OFF_ERR, s);
    chk({31'h0, s[ER_MED]}, 32'h1);
    err_at = n_done + 10'h1;
    run(OP_WR_MUL, 8'h02, 28'h70, 4'h7);
    chk({16'h0, n_words - w0}, 32'd8);
    rd(OFF_ERR, s);
    chk({31'h0, s[ER_MED]}, 32'h1);
    err_at = n_done + 10'h1;
    run(OP_WR_SEC, 8'h01, 28'h70, 4'h7);
    rd(OFF_ADDR, s);
    chk(s, 32'h70);
    rd(OFF_ERR, s);
    chk({31'h0, s[ER_MED]}, 32'h1);
    err_at = 10'h0;
    $display("test errors done");
    close_out();
  end

  initial begin
    repeat (80000) @(posedge ref_clk);
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out();
  end
endmodule
